// ===== common/flash_seq_consts.vh
// Constants for the flash erase check and suspend sequencer.
// Assumes a 20 MHz core clock; included by the sequencer, the bench top and the checker.
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
// Instruction codes.
`define CMD_ERASE_CHECK 8'hd0
`define CMD_PAUSE_A 8'h85
`define CMD_PAUSE_B 8'h75
`define CMD_PAUSE_C 8'hb0
`define CMD_RESUME_A 8'h7a
`define CMD_RESUME_B 8'h8a
`define CMD_RD_STATUS_ONE 8'h05
`define CMD_RD_STATUS_TWO 8'h07
`define CMD_RD_ANY_REG 8'h65
`define CMD_WRITE_ENABLE 8'h06
`define CMD_PAGE_PROG 8'h02
`define CMD_PAGE_PROG_WIDE 8'h12
`define CMD_ARRAY_READ 8'h03
`define CMD_ARRAY_READ_WIDE 8'h13
`define CMD_RESET_ARM 8'h66
`define CMD_RESET_DO 8'h99
`define CMD_SECTOR_ERASE 8'hd8
`define CMD_SECTOR_ERASE_WIDE 8'hdc
`define CMD_BULK_ERASE 8'h60
`define CMD_BULK_ERASE_ALT 8'hc7
`define CMD_PROT_RD 8'hfa
`define CMD_PROT_WR 8'hfb
// Status bit positions.
`define ST1_WIP 0
`define ST1_WEL 1
`define ST2_PROG_PAUSED 0
`define ST2_ERASE_PAUSED 1
`define ST2_ERASE_OK 2
`define ST2_PROG_ERR 3
// Config bit: wide (4-byte) address when set.
`define CFG2_ADDR_WIDE 7
// Timing in ns and derived 20 MHz cycle counts.
`define CLK_PERIOD_NS 50
`define ERASE_CHECK_NS 20000
`define ERASE_CHECK_CYC (`ERASE_CHECK_NS / `CLK_PERIOD_NS)
`define PAUSE_LAT_NS 10000
`define PAUSE_LAT_CYC (`PAUSE_LAT_NS / `CLK_PERIOD_NS)
`define PROG_NS 40000
`define PROG_CYC (`PROG_NS / `CLK_PERIOD_NS)
`define ERASE_NS 160000
`define ERASE_CYC (`ERASE_NS / `CLK_PERIOD_NS)
// AXI register byte offsets and response codes.
`define REG_STATUS_ONE 8'h00
`define REG_STATUS_TWO 8'h04
`define REG_CONFIG_TWO 8'h08
`define REG_MODE 8'h0c
`define REG_PAUSED_ADDR 8'h10
`define REG_OKAY 2'b00
`define REG_DECERR 2'b11
`endif

// ===== rtl/flash_erase_check_and_suspend.v
// Command sequencer for erase check and program/erase pause inside a serial flash.
// Assumes the SPI pins are asynchronous to aclk and SCK runs well below aclk / 4.
`timescale 1ns/1ps
`include "flash_seq_consts.vh"

// Functional notes
// - Erase check sets erase-ok bit to 1 if sector's last erase finished, else 0.
// - Erase check carries 3 or 4 address bytes, chosen by the address-width config bit.
// - Erase check takes a fixed time; write in progress stays high until done.
// - Erase check needs no write enable; device sets and later clears the latch.
// - In four-wire mode each byte takes two clocks on all four data lines.
// - Three alternative codes all act as the pause command.
// - Pause acts only during page program or sector erase, never bulk erase.
// - Status two holds program-paused and erase-paused bits.
// - Reads allowed except of the paused sector or paused page.
// - Erase pause permits program, read and protection-bit access.
// - Program pause permits only reads.
// - New erase commands are ignored while anything is paused.
// - Page programs in erase pause are accepted only if no program is paused.
// - Program into the erase-paused sector fails and sets program error.
// - Array reads of both address widths accepted in both pause kinds.
// - Status reads accepted in both pause kinds.
// - Write enable accepted in erase pause but not program pause.
// - Either resume code resumes a paused operation.
// - Reset arm and reset accepted at any time, even while paused.
module flash_erase_check_and_suspend #(
   parameter SECTOR_BITS = 16,
   parameter PAGE_BITS = 8,
   parameter ERASE_CYCLES = `ERASE_CYC,
   parameter CHECK_CYCLES = `ERASE_CHECK_CYC
) (
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // SPI pins.
   input wire cs_n,
   input wire sck,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe,
   // AXI4-Lite write.
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read.
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam [2:0] OP_IDLE = 3'd0;
   localparam [2:0] OP_CHECK = 3'd1;
   localparam [2:0] OP_PROG = 3'd2;
   localparam [2:0] OP_ERASE = 3'd3;
   localparam [2:0] OP_BULK = 3'd4;
   localparam [2:0] OP_PAUSING = 3'd5;
   localparam [31:0] CNT_PROG = `PROG_CYC;
   localparam [31:0] CNT_PAUSE = `PAUSE_LAT_CYC;

   // ****************************************************************
   // Pin synchronisers and SCK edge detection
   // ****************************************************************
   reg [5:0] sync1_reg;
   reg [5:0] sync2_reg;
   reg sck_prev_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 6'h20;
         sync2_reg <= 6'h20;
         sck_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= {cs_n, sck, io_in};
         sync2_reg <= sync1_reg;
         sck_prev_reg <= sync2_reg[4];
      end
   end
   wire cs_s = sync2_reg[5];
   wire sck_rise = sync2_reg[4] & ~sck_prev_reg;
   wire [3:0] io_s = sync2_reg[3:0];

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   reg [7:0] cfg2_reg;
   reg quad_reg;
   reg wip_reg, wel_reg;
   reg prog_paused_reg, erase_paused_reg, erase_ok_reg, prog_err_reg;
   reg [2:0] op_reg, paused_op_reg;
   reg [31:0] cnt_reg, paused_cnt_reg, prog_cnt_reg;
   reg [31:0] op_addr_reg, erase_pause_addr_reg, prog_pause_addr_reg;
   reg [SECTOR_BITS-1:0] done_mark_reg;
   reg [7:0] cmd_reg;
   reg [31:0] addr_reg;
   reg [5:0] bits_reg;
   reg cs_prev_reg, reset_armed_reg, read_refused_reg;

   wire wide = cfg2_reg[`CFG2_ADDR_WIDE];
   wire [5:0] need_bits = wide ? 6'd40 : 6'd32;
   wire [5:0] step = quad_reg ? 6'd4 : 6'd1;
   wire any_paused = prog_paused_reg | erase_paused_reg;
   wire busy = (op_reg != OP_IDLE);
   wire frame_end = cs_s & ~cs_prev_reg;
   wire [SECTOR_BITS-1:0] sect_bit = {{(SECTOR_BITS-1){1'b0}}, 1'b1};
   wire [SECTOR_BITS-1:0] sect_sel = sect_bit << addr_reg[SECTOR_BITS+15:16];
   wire same_sector = (addr_reg[31:16] == erase_pause_addr_reg[31:16]);
   wire same_page = (addr_reg[31:PAGE_BITS] == prog_pause_addr_reg[31:PAGE_BITS]);
   wire is_pause = (cmd_reg == `CMD_PAUSE_A) | (cmd_reg == `CMD_PAUSE_B)
                 | (cmd_reg == `CMD_PAUSE_C);
   wire is_resume = (cmd_reg == `CMD_RESUME_A) | (cmd_reg == `CMD_RESUME_B);
   wire is_prog = (cmd_reg == `CMD_PAGE_PROG) | (cmd_reg == `CMD_PAGE_PROG_WIDE);
   wire is_erase = (cmd_reg == `CMD_SECTOR_ERASE) | (cmd_reg == `CMD_SECTOR_ERASE_WIDE);
   wire is_bulk = (cmd_reg == `CMD_BULK_ERASE) | (cmd_reg == `CMD_BULK_ERASE_ALT);
   wire is_read = (cmd_reg == `CMD_ARRAY_READ) | (cmd_reg == `CMD_ARRAY_READ_WIDE);
   wire addr_done = (bits_reg >= need_bits);
   // A read into the paused sector or page is refused; the flag is visible to software.
   wire read_blocked = is_read & ((erase_paused_reg & same_sector) | (prog_paused_reg & same_page));
   // Commands permitted while something is paused.
   wire allowed_in_pause =
        is_read | (cmd_reg == `CMD_RD_STATUS_ONE) | (cmd_reg == `CMD_RD_STATUS_TWO)
      | (cmd_reg == `CMD_RD_ANY_REG) | is_resume
      | (cmd_reg == `CMD_RESET_ARM) | (cmd_reg == `CMD_RESET_DO)
      | (~prog_paused_reg & ((cmd_reg == `CMD_WRITE_ENABLE) | is_prog
         | (cmd_reg == `CMD_PROT_RD) | (cmd_reg == `CMD_PROT_WR)));

   // ****************************************************************
   // SPI command shifter and sequencer
   // ****************************************************************
   always @(posedge aclk) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      if (!aresetn) begin
         cfg2_reg <= 8'h00;
         quad_reg <= 1'b0;
         wip_reg <= 1'b0;
         wel_reg <= 1'b0;
         prog_paused_reg <= 1'b0;
         erase_paused_reg <= 1'b0;
         erase_ok_reg <= 1'b0;
         prog_err_reg <= 1'b0;
         op_reg <= OP_IDLE;
         paused_op_reg <= OP_IDLE;
         cnt_reg <= 32'd0;
         paused_cnt_reg <= 32'd0;
         prog_cnt_reg <= 32'd0;
         op_addr_reg <= 32'd0;
         erase_pause_addr_reg <= 32'd0;
         prog_pause_addr_reg <= 32'd0;
         done_mark_reg <= {SECTOR_BITS{1'b0}};
         cmd_reg <= 8'h00;
         addr_reg <= 32'd0;
         bits_reg <= 6'd0;
         cs_prev_reg <= 1'b1;
         reset_armed_reg <= 1'b0;
         read_refused_reg <= 1'b0;
      end else begin
         cs_prev_reg <= cs_s;
         if (cs_s) begin
            bits_reg <= 6'd0;
            addr_reg <= 32'd0;
         end else if (sck_rise && bits_reg < 6'd40) begin
            bits_reg <= bits_reg + step;
            if (bits_reg < 6'd8) begin
               cmd_reg <= quad_reg ? {cmd_reg[3:0], io_s} : {cmd_reg[6:0], io_s[0]};
            end else begin
               addr_reg <= quad_reg ? {addr_reg[27:0], io_s} : {addr_reg[30:0], io_s[0]};
            end
         end
         // Internal operation timer.
         if (busy) begin
            if (cnt_reg <= 32'd1) begin
               case (op_reg)
                  OP_CHECK: erase_ok_reg <= |(done_mark_reg & (sect_bit << op_addr_reg[SECTOR_BITS+15:16]));
                  OP_ERASE: done_mark_reg <= done_mark_reg | (sect_bit << op_addr_reg[SECTOR_BITS+15:16]);
                  OP_BULK: done_mark_reg <= {SECTOR_BITS{1'b1}};
                  OP_PAUSING: begin
                     if (paused_op_reg == OP_PROG) begin
                        prog_paused_reg <= 1'b1;
                        prog_pause_addr_reg <= op_addr_reg;
                     end else begin
                        erase_paused_reg <= 1'b1;
                        erase_pause_addr_reg <= op_addr_reg;
                     end
                  end
                  default: ;
               endcase
               op_reg <= OP_IDLE;
               wip_reg <= 1'b0;
               wel_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_reg - 32'd1;
            end
         end
         // Register writes come before the frame logic so a program error set in the same cycle outlives its clear.
         if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
            if (s_axi_awaddr == `REG_CONFIG_TWO && s_axi_wstrb[0])
               cfg2_reg <= s_axi_wdata[7:0];
            if (s_axi_awaddr == `REG_MODE && s_axi_wstrb[0])
               quad_reg <= s_axi_wdata[0];
            if (s_axi_awaddr == `REG_STATUS_TWO && s_axi_wstrb[0] && s_axi_wdata[`ST2_PROG_ERR])
               prog_err_reg <= 1'b0;
         end
         // Command executes when the frame closes.
         if (frame_end && bits_reg >= 6'd8) begin
            reset_armed_reg <= (cmd_reg == `CMD_RESET_ARM);
            read_refused_reg <= read_blocked;
            if (cmd_reg == `CMD_RESET_DO && reset_armed_reg) begin
               op_reg <= OP_IDLE;
               wip_reg <= 1'b0;
               wel_reg <= 1'b0;
               prog_paused_reg <= 1'b0;
               erase_paused_reg <= 1'b0;
            end else if (is_pause) begin
               if (op_reg == OP_PROG || op_reg == OP_ERASE) begin
                  paused_op_reg <= op_reg;
                  if (op_reg == OP_PROG)
                     prog_cnt_reg <= cnt_reg;
                  else
                     paused_cnt_reg <= cnt_reg;
                  op_reg <= OP_PAUSING;
                  cnt_reg <= CNT_PAUSE;
               end
            end else if (any_paused && !busy) begin
               if (is_resume) begin
                  if (prog_paused_reg) begin
                     prog_paused_reg <= 1'b0;
                     op_reg <= OP_PROG;
                     op_addr_reg <= prog_pause_addr_reg;
                     cnt_reg <= prog_cnt_reg;
                  end else begin
                     erase_paused_reg <= 1'b0;
                     op_reg <= OP_ERASE;
                     op_addr_reg <= erase_pause_addr_reg;
                     cnt_reg <= paused_cnt_reg;
                  end
                  wip_reg <= 1'b1;
               end else if (allowed_in_pause) begin
                  if (cmd_reg == `CMD_WRITE_ENABLE)
                     wel_reg <= 1'b1;
                  else if (is_prog && addr_done && wel_reg) begin
                     if (same_sector) begin
                        prog_err_reg <= 1'b1;
                        wel_reg <= 1'b0;
                     end else begin
                        op_reg <= OP_PROG;
                        op_addr_reg <= addr_reg;
                        cnt_reg <= CNT_PROG;
                        wip_reg <= 1'b1;
                     end
                  end
               end
            end else if (!busy) begin
               if (cmd_reg == `CMD_ERASE_CHECK && addr_done) begin
                  op_reg <= OP_CHECK;
                  op_addr_reg <= addr_reg;
                  cnt_reg <= CHECK_CYCLES;
                  wip_reg <= 1'b1;
                  wel_reg <= 1'b1;
               end else if (cmd_reg == `CMD_WRITE_ENABLE) begin
                  wel_reg <= 1'b1;
               end else if (wel_reg && addr_done && (is_prog || is_erase)) begin
                  op_reg <= is_prog ? OP_PROG : OP_ERASE;
                  op_addr_reg <= addr_reg;
                  cnt_reg <= is_prog ? CNT_PROG : ERASE_CYCLES;
                  if (is_erase)
                     done_mark_reg <= done_mark_reg & ~sect_sel;
                  wip_reg <= 1'b1;
               end else if (wel_reg && is_bulk) begin
                  op_reg <= OP_BULK;
                  cnt_reg <= ERASE_CYCLES;
                  done_mark_reg <= {SECTOR_BITS{1'b0}};
                  wip_reg <= 1'b1;
               end
            end
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire wr_ok = (s_axi_awaddr == `REG_CONFIG_TWO) | (s_axi_awaddr == `REG_MODE)
              | (s_axi_awaddr == `REG_STATUS_TWO);
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `REG_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `REG_OKAY;
         s_axi_rdata <= 32'd0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `REG_OKAY : `REG_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `REG_OKAY;
            case (s_axi_araddr)
               `REG_STATUS_ONE: s_axi_rdata <= {30'd0, wel_reg, wip_reg};
               `REG_STATUS_TWO: s_axi_rdata <= {27'd0, read_refused_reg, prog_err_reg, erase_ok_reg,
                                                erase_paused_reg, prog_paused_reg};
               `REG_CONFIG_TWO: s_axi_rdata <= {24'd0, cfg2_reg};
               `REG_MODE: s_axi_rdata <= {31'd0, quad_reg};
               `REG_PAUSED_ADDR: s_axi_rdata <= erase_pause_addr_reg;
               default: begin
                  s_axi_rdata <= 32'd0;
                  s_axi_rresp <= `REG_DECERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // flash_erase_check_and_suspend

// ===== sim/flash_erase_check_and_suspend_tb_top.sv
// Self-checking bench for the erase check and pause sequencer.
// Assumes the host model on the link and the checker bound to the sequencer.
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module flash_erase_check_and_suspend_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   wire cs_n, sck;
   wire [3:0] io_in, io_out, io_oe;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [31:0] exp_d[$], exp_m[$], last, ra, m, e;
   logic [1:0] exp_r[$], exp_b[$];
   logic [7:0] pc[3] = '{`CMD_PAUSE_A, `CMD_PAUSE_B, `CMD_PAUSE_C};
   int failures = 0, n_compared = 0, cycles = 0;
   always #25 aclk = ~aclk;
   // Long erases keep a pause inside the run; the check stays longer than a status read.
   flash_erase_check_and_suspend #(.ERASE_CYCLES(2000), .CHECK_CYCLES(40)) flash_erase_check_and_suspend_i (
      .aclk, .aresetn, .cs_n, .sck, .io_in, .io_out, .io_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   spi_host spi_host_i (.cs_n, .sck, .io(io_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `REG_OKAY);
      @(posedge aclk);
      exp_b.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r = `REG_OKAY);
      @(posedge aclk);
      exp_d.push_back(e);
      exp_m.push_back(m);
      exp_r.push_back(r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      last = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask
   task automatic poll;
      do rd(`REG_STATUS_ONE, 32'h0, 32'h0); while (last[`ST1_WIP] !== 1'b0);
   endtask
   task automatic spi(input logic [7:0] op, input logic [31:0] ad = 32'h0, input int nab = 4, input bit q = 1'b0);
      spi_host_i.frame(op, ad, nab, q);
      repeat (6) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         m = exp_m.pop_front();
         e = exp_d.pop_front();
         chk({30'h0, s_axi_rresp}, {30'h0, exp_r.pop_front()});
         if (m != 32'h0) chk(s_axi_rdata & m, e & m);
      end
      if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp}, {30'h0, exp_b.pop_front()});
      cycles++;
      if (cycles == 60000) begin
         failures++;
         stop_test;
      end
   end
   // ****************************************
   // Scenarios.
   // ****************************************
   initial begin
      void'($urandom(32'ha5ce));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(`REG_STATUS_ONE, 32'h0, 32'h3);
      rd(8'h14, 32'h0, 32'hffffffff, `REG_DECERR);
      wr(8'h20, 32'h0, `REG_DECERR);
      wr(`REG_CONFIG_TWO, 32'h0);
      rd(`REG_CONFIG_TWO, 32'h0, 32'h80);
      ra = {16'h0001, 16'($urandom)};
      spi(`CMD_ERASE_CHECK, ra, 3);
      rd(`REG_STATUS_ONE, 32'h3, 32'h3);
      poll;
      rd(`REG_STATUS_ONE, 32'h0, 32'h3);
      rd(`REG_STATUS_TWO, 32'h0, 32'h4);
      // A sector found not erased is erased again before it is trusted.
      spi(`CMD_WRITE_ENABLE);
      spi(`CMD_SECTOR_ERASE, ra, 3);
      poll;
      wr(`REG_CONFIG_TWO, 32'h80);
      spi(`CMD_ERASE_CHECK, ra);
      poll;
      rd(`REG_STATUS_TWO, 32'h4, 32'h4);
      wr(`REG_MODE, 32'h1);
      spi(`CMD_ERASE_CHECK, 32'h0006_0000, 4, 1'b1);
      poll;
      rd(`REG_STATUS_TWO, 32'h0, 32'h4);
      wr(`REG_MODE, 32'h0);
      spi(`CMD_WRITE_ENABLE);
      spi(`CMD_PAGE_PROG, {16'h0005, 16'($urandom)});
      spi(`CMD_PAUSE_A);
      poll;
      rd(`REG_STATUS_TWO, 32'h1, 32'h3);
      spi(`CMD_WRITE_ENABLE);
      rd(`REG_STATUS_ONE, 32'h0, 32'h2);
      spi(`CMD_ARRAY_READ_WIDE, 32'h0004_0000);
      rd(`REG_STATUS_TWO, 32'h0, 32'h10);
      spi(`CMD_SECTOR_ERASE, 32'h0003_0000);
      rd(`REG_STATUS_ONE, 32'h0, 32'h1);
      spi(`CMD_RESUME_B);
      rd(`REG_STATUS_TWO, 32'h0, 32'h1);
      rd(`REG_STATUS_ONE, 32'h1, 32'h1);
      poll;
      for (int i = 0; i < 3; i++) begin
         spi(`CMD_WRITE_ENABLE);
         spi(`CMD_SECTOR_ERASE, 32'h0002_0000);
         spi(pc[i]);
         poll;
         rd(`REG_STATUS_TWO, 32'h2, 32'h3);
         spi(`CMD_WRITE_ENABLE);
         rd(`REG_STATUS_ONE, 32'h2, 32'h2);
         spi(`CMD_SECTOR_ERASE, 32'h0003_0000);
         rd(`REG_STATUS_ONE, 32'h0, 32'h1);
         spi(`CMD_WRITE_ENABLE);
         if (i == 0) begin
            spi(`CMD_PAGE_PROG, {16'h0002, 16'($urandom)});
            poll;
            rd(`REG_STATUS_TWO, 32'h8, 32'h8);
            wr(`REG_STATUS_TWO, 32'h8);
            rd(`REG_STATUS_TWO, 32'h0, 32'h8);
         end
         if (i == 1) begin
            spi(`CMD_PAGE_PROG_WIDE, {16'h0004, 16'($urandom)});
            rd(`REG_STATUS_ONE, 32'h1, 32'h1);
            poll;
         end
         if (i == 2) begin
            spi(`CMD_ARRAY_READ, 32'h0002_0000);
            rd(`REG_STATUS_TWO, 32'h10, 32'h10);
         end
         spi(i[0] ? `CMD_RESUME_B : `CMD_RESUME_A);
         rd(`REG_STATUS_TWO, 32'h0, 32'h2);
         rd(`REG_STATUS_ONE, 32'h1, 32'h1);
         poll;
      end
      spi(`CMD_WRITE_ENABLE);
      spi(`CMD_BULK_ERASE, 32'h0, 0);
      spi(`CMD_PAUSE_B);
      repeat (400) @(posedge aclk);
      rd(`REG_STATUS_ONE, 32'h1, 32'h1);
      rd(`REG_STATUS_TWO, 32'h0, 32'h2);
      poll;
      spi(`CMD_ERASE_CHECK, 32'h0006_0000);
      poll;
      rd(`REG_STATUS_TWO, 32'h4, 32'h4);
      // A paused erase cut off by a software reset must read as not erased afterwards.
      spi(`CMD_WRITE_ENABLE);
      spi(`CMD_SECTOR_ERASE, 32'h0007_0000);
      spi(`CMD_PAUSE_C);
      poll;
      spi(`CMD_RESET_ARM);
      spi(`CMD_RESET_DO);
      rd(`REG_STATUS_TWO, 32'h0, 32'h3);
      spi(`CMD_ERASE_CHECK, 32'h0007_0000);
      poll;
      rd(`REG_STATUS_TWO, 32'h0, 32'h4);
      stop_test;
   end
endmodule // flash_erase_check_and_suspend_tb_top

// ===== sim/seq_monitor.sv
// Checker for the register port and pins of the erase check and pause sequencer.
// Assumes it is bound to the sequencer and sees only that module's ports.
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module seq_monitor (
   // Clock, reset and pins.
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] io_oe,
   // Register port.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire rd_take = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
   wire wr_map = s_axi_awaddr <= `REG_PAUSED_ADDR && s_axi_awaddr[1:0] == 2'b00;
   wire rd_map = s_axi_araddr <= `REG_PAUSED_ADDR && s_axi_araddr[1:0] == 2'b00;
   wr_answer_a: assert property (wr_take |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
      else $error("write not answered");
   ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready && !s_axi_wready)
      else $error("write ready too long");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rd_answer_a: assert property (rd_take |=> s_axi_arready && s_axi_rvalid)
      else $error("read not answered");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   rd_refuse_a: assert property (rd_take && !rd_map |=> s_axi_rresp == `REG_DECERR && s_axi_rdata == 32'h0)
      else $error("unmapped read accepted");
   rd_okay_a: assert property (rd_take && rd_map |=> s_axi_rresp == `REG_OKAY)
      else $error("mapped read refused");
   wr_refuse_a: assert property (wr_take && !wr_map |=> s_axi_bresp == `REG_DECERR)
      else $error("unmapped write accepted");
   pins_quiet_a: assert property (io_oe == 4'h0)
      else $error("data pins driven");
endmodule // seq_monitor
bind flash_erase_check_and_suspend seq_monitor seq_monitor_i (.aclk(aclk), .aresetn(aresetn), .io_oe(io_oe),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== sim/spi_host.sv
// Host side of the serial flash link: frames commands on select, clock and data.
// Assumes frame is called from one process; the link clock stands still between frames.
`timescale 1ns/1ps
module spi_host (
   // Link pins.
   output logic cs_n,
   output logic sck,
   output logic [3:0] io
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io = 4'h0;
   end
   task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int nab, input bit quad);
      logic [39:0] sh;
      sh = {op, ad << (8 * (4 - nab))};
      #7 cs_n = 1'b0;
      for (int i = 0; i < 8 + 8 * nab; i += (quad ? 4 : 1)) begin
         // Unused lines toggle so a stale level is never mistaken for data.
         io = quad ? sh[39 - i -: 4] : {~io[3:1], sh[39 - i]};
         #200 sck = 1'b1;
         #200 sck = 1'b0;
      end
      #200 cs_n = 1'b1;
      io = ~io;
   endtask
endmodule // spi_host
